/* File: logic/fcse_host.sv */
`timescale 1ns/1ps
module fcse_host #(
    // Command codes, arbitrary defaults; set to the device's codes
    parameter logic [7:0] CMD_READ_ID = 8'h01,
    parameter logic [7:0] CMD_READ_STATUS = 8'h02,
    parameter logic [7:0] CMD_CLEAR_STATUS = 8'h03,
    parameter logic [7:0] CMD_BUFFER_SETUP = 8'h04,
    parameter logic [7:0] CMD_ERASE_SETUP = 8'h05,
    parameter logic [7:0] CMD_CHIP_SETUP = 8'h06,
    parameter logic [7:0] CMD_CONFIRM = 8'h07
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire fcse_pkg::fcse_req_type req,
    output logic req_ready,
    output fcse_pkg::fcse_pins_type pins,
    input wire logic [fcse_pkg::DATA_W-1:0] dq_in,
    input wire logic status_pin,
    output logic done,
    output logic [fcse_pkg::DATA_W-1:0] result,
    output logic erase_failed
);
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_WR = 6'b000010,
        S_WREC = 6'b000100,
        S_RD = 6'b001000,
        S_RREC = 6'b010000,
        S_WAIT = 6'b100000
    } fcse_state_type;

    fcse_state_type state_q, state_d;
    fcse_pkg::fcse_pins_type pins_q, pins_d;
    fcse_pkg::fcse_op_type op_q, op_d;
    logic [fcse_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [1:0] step_q, step_d;
    logic [1:0] wr_cnt_q, wr_cnt_d;
    logic [fcse_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [fcse_pkg::DATA_W-1:0] data_q, data_d;
    logic [fcse_pkg::DATA_W-1:0] result_q, result_d;
    logic ready_q, ready_d;
    logic done_q, done_d;
    logic efail_q, efail_d;
    logic [fcse_pkg::DATA_W-1:0] dq_meta_q, dq_sync_q;
    logic sts_meta_q, sts_sync_q;
    logic is_erase;

    // Two-stage synchronisers for device pins
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dq_meta_q <= '0;
            dq_sync_q <= '0;
            sts_meta_q <= 1'b0;
            sts_sync_q <= 1'b0;
        end else begin
            dq_meta_q <= dq_in;
            dq_sync_q <= dq_meta_q;
            sts_meta_q <= status_pin;
            sts_sync_q <= sts_meta_q;
        end
    end

    // First command byte of each operation
    function automatic logic [7:0] first_cmd(input fcse_pkg::fcse_op_type op);
        logic [7:0] c;
        c = CMD_READ_STATUS;
        unique case (op)
            fcse_pkg::OP_READ_ID: c = CMD_READ_ID;
            fcse_pkg::OP_READ_STATUS: c = CMD_READ_STATUS;
            fcse_pkg::OP_CLEAR_STATUS: c = CMD_CLEAR_STATUS;
            fcse_pkg::OP_READ_XSR: c = CMD_BUFFER_SETUP;
            fcse_pkg::OP_BLOCK_ERASE: c = CMD_ERASE_SETUP;
            fcse_pkg::OP_CHIP_ERASE: c = CMD_CHIP_SETUP;
            default: c = CMD_READ_STATUS;
        endcase
        return c;
    endfunction

    assign is_erase = (op_q == fcse_pkg::OP_BLOCK_ERASE) || (op_q == fcse_pkg::OP_CHIP_ERASE);

    // Sequencer: command writes, status polling and result reads
    always_comb begin
        state_d = state_q;
        pins_d = pins_q;
        op_d = op_q;
        addr_d = addr_q;
        step_d = step_q;
        wr_cnt_d = wr_cnt_q;
        cnt_d = cnt_q + 1'b1;
        data_d = data_q;
        result_d = result_q;
        ready_d = ready_q;
        done_d = 1'b0;
        efail_d = efail_q;
        unique case (state_q)
            S_IDLE: begin
                cnt_d = '0;
                if (req_valid && ready_q) begin
                    op_d = req.op;
                    addr_d = req.addr;
                    step_d = fcse_pkg::STEP_CMD1;
                    wr_cnt_d = '0;
                    ready_d = 1'b0;
                    pins_d.wp_n = req.wp_high;
                    pins_d.addr = req.addr;
                    pins_d.dq_out = first_cmd(req.op);
                    pins_d.dq_oe = 1'b1;
                    pins_d.ce_a_n = 1'b0;
                    pins_d.ce_b_n = 1'b0;
                    pins_d.we_n = 1'b0;
                    state_d = S_WR;
                end
            end
            S_WR: begin
                // Write pulse; enables rise together, data held into recovery
                if (cnt_q == fcse_pkg::CNT_W'(fcse_pkg::WE_CYC - 1)) begin
                    pins_d.we_n = 1'b1;
                    pins_d.ce_a_n = 1'b1;
                    pins_d.ce_b_n = 1'b1;
                    cnt_d = '0;
                    state_d = S_WREC;
                end
            end
            S_WREC: begin
                if (cnt_q == fcse_pkg::CNT_W'(fcse_pkg::REC_CYC - 1)) begin
                    pins_d.dq_oe = 1'b0;
                    cnt_d = '0;
                    wr_cnt_d = wr_cnt_q + 1'b1;
                    if (step_q == fcse_pkg::STEP_CMD1 && is_erase) begin
                        // Confirm goes to an address inside the target block
                        step_d = fcse_pkg::STEP_CMD2;
                        pins_d.dq_out = CMD_CONFIRM;
                        pins_d.dq_oe = 1'b1;
                        pins_d.ce_a_n = 1'b0;
                        pins_d.ce_b_n = 1'b0;
                        pins_d.we_n = 1'b0;
                        state_d = S_WR;
                    end else if (step_q == fcse_pkg::STEP_CMD2) begin
                        step_d = fcse_pkg::STEP_POLL;
                        state_d = S_WAIT;
                    end else if (step_q == fcse_pkg::STEP_CLEAR ||
                                 op_q == fcse_pkg::OP_CLEAR_STATUS) begin
                        done_d = 1'b1;
                        ready_d = 1'b1;
                        state_d = S_IDLE;
                    end else begin
                        // Identifier reads skip the lowest address line
                        pins_d.addr = (op_q == fcse_pkg::OP_READ_ID) ?
                            {addr_q[fcse_pkg::ADDR_W-2:0], 1'b0} : addr_q;
                        pins_d.oe_n = 1'b0;
                        pins_d.ce_a_n = 1'b0;
                        pins_d.ce_b_n = 1'b0;
                        state_d = S_RD;
                    end
                end
            end
            S_WAIT: begin
                // Hold off status reads while the status pin shows busy
                cnt_d = '0;
                if (sts_sync_q) begin
                    pins_d.oe_n = 1'b0;
                    pins_d.ce_a_n = 1'b0;
                    pins_d.ce_b_n = 1'b0;
                    state_d = S_RD;
                end
            end
            S_RD: begin
                if (cnt_q == fcse_pkg::CNT_W'(fcse_pkg::RD_CYC + fcse_pkg::SYNC_CYC - 1)) begin
                    data_d = dq_sync_q;
                    // Enables return high so the next read relatches
                    pins_d.oe_n = 1'b1;
                    pins_d.ce_a_n = 1'b1;
                    pins_d.ce_b_n = 1'b1;
                    cnt_d = '0;
                    state_d = S_RREC;
                end
            end
            S_RREC: begin
                if (cnt_q == fcse_pkg::CNT_W'(fcse_pkg::REC_CYC - 1)) begin
                    cnt_d = '0;
                    if (step_q == fcse_pkg::STEP_POLL && !data_q[fcse_pkg::ENGINE_READY_BIT]) begin
                        state_d = S_WAIT;
                    end else if (step_q == fcse_pkg::STEP_POLL &&
                                 data_q[fcse_pkg::ERASE_FAIL_BIT]) begin
                        // Failed erase: clear status before reporting
                        result_d = data_q;
                        efail_d = 1'b1;
                        step_d = fcse_pkg::STEP_CLEAR;
                        pins_d.dq_out = CMD_CLEAR_STATUS;
                        pins_d.dq_oe = 1'b1;
                        pins_d.ce_a_n = 1'b0;
                        pins_d.ce_b_n = 1'b0;
                        pins_d.we_n = 1'b0;
                        state_d = S_WR;
                    end else begin
                        result_d = data_q;
                        efail_d = 1'b0;
                        done_d = 1'b1;
                        ready_d = 1'b1;
                        state_d = S_IDLE;
                    end
                end
            end
            default: begin
                state_d = S_IDLE;
                pins_d = fcse_pkg::PINS_RESET;
                ready_d = 1'b1;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            pins_q <= fcse_pkg::PINS_RESET;
            op_q <= fcse_pkg::OP_READ_STATUS;
            addr_q <= '0;
            step_q <= fcse_pkg::STEP_CMD1;
            wr_cnt_q <= '0;
            cnt_q <= '0;
            data_q <= '0;
            result_q <= '0;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            efail_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pins_q <= pins_d;
            op_q <= op_d;
            addr_q <= addr_d;
            step_q <= step_d;
            wr_cnt_q <= wr_cnt_d;
            cnt_q <= cnt_d;
            data_q <= data_d;
            result_q <= result_d;
            ready_q <= ready_d;
            done_q <= done_d;
            efail_q <= efail_d;
        end
    end

    assign pins = pins_q;
    assign req_ready = ready_q;
    assign done = done_q;
    assign result = result_q;
    assign erase_failed = efail_q;

    // Checks on the host's own pin behaviour and sequencing
    sequence write_pulse_s;
        !pins_q.we_n [*5] ##1 pins_q.we_n;
    endsequence

    sequence enables_high_s;
        pins_q.oe_n [*3];
    endsequence

    AST_OE_RECOVERY: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(pins_q.oe_n) |-> enables_high_s)
        else $error("output enable low again too soon");
    AST_NO_BUS_CLASH: assert property (@(posedge clk_sys) disable iff (rst)
        pins_q.dq_oe |-> pins_q.oe_n)
        else $error("data driven during a read");
    AST_WE_WIDTH: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(pins_q.we_n) |-> write_pulse_s)
        else $error("write pulse width wrong");
    AST_ERASE_TWO_WRITES: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == S_WAIT) |-> (wr_cnt_q == 2'h2) && is_erase)
        else $error("polling without setup and confirm");
    AST_XSR_REISSUE: assert property (@(posedge clk_sys) disable iff (rst)
        ($fell(pins_q.oe_n) && op_q == fcse_pkg::OP_READ_XSR) |-> (wr_cnt_q == 2'h1))
        else $error("extended status read without fresh setup");
    AST_POLL_WAITS_PIN: assert property (@(posedge clk_sys) disable iff (rst)
        (state_q == S_WAIT && !sts_sync_q) |=> pins_q.oe_n)
        else $error("status read while pin shows busy");
    AST_CLEAR_AFTER_FAIL: assert property (@(posedge clk_sys) disable iff (rst)
        (done_q && efail_q && is_erase) |-> (step_q == fcse_pkg::STEP_CLEAR) &&
        $past(pins_q.dq_out, 5) ==
        CMD_CLEAR_STATUS)
        else $error("erase failure reported without clearing status");
    AST_DONE_PULSE: assert property (@(posedge clk_sys) disable iff (rst)
        done_q |-> ready_q ##1 !done_q)
        else $error("done not a single pulse with ready");
    AST_READY_BEFORE_DONE: assert property (@(posedge clk_sys) disable iff (rst)
        (done_q && is_erase) |-> result_q[fcse_pkg::ENGINE_READY_BIT])
        else $error("erase finished before ready bit seen");
endmodule

/* File: include/fcse_pkg.sv */
package fcse_pkg;
    localparam int CLK_MHZ = 100;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 8;
    localparam int CNT_W = 8;
    // Bus timing in ns and derived cycle counts (least times, rounded up)
    localparam int T_WE_NS = 50;
    localparam int WE_CYC = (T_WE_NS * CLK_MHZ + 999) / 1000;
    localparam int T_RD_NS = 100;
    localparam int RD_CYC = (T_RD_NS * CLK_MHZ + 999) / 1000;
    localparam int T_REC_NS = 30;
    localparam int REC_CYC = (T_REC_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_CYC = 2;
    // Status byte field positions
    localparam int ENGINE_READY_BIT = 7;
    localparam int ERASE_FAIL_BIT = 5;
    localparam int PROGRAM_FAIL_BIT = 4;
    localparam int SUPPLY_LOCKOUT_BIT = 3;
    localparam int LOCK_VIOLATION_BIT = 1;
    // Sequence steps within one operation
    localparam logic [1:0] STEP_CMD1 = 2'h0;
    localparam logic [1:0] STEP_CMD2 = 2'h1;
    localparam logic [1:0] STEP_POLL = 2'h2;
    localparam logic [1:0] STEP_CLEAR = 2'h3;

    typedef enum logic [2:0] {
        OP_READ_ID = 3'h0,
        OP_READ_STATUS = 3'h1,
        OP_CLEAR_STATUS = 3'h2,
        OP_READ_XSR = 3'h3,
        OP_BLOCK_ERASE = 3'h4,
        OP_CHIP_ERASE = 3'h5
    } fcse_op_type;

    typedef struct packed {
        fcse_op_type op;
        logic [ADDR_W-1:0] addr;
        logic wp_high;
    } fcse_req_type;

    typedef struct packed {
        logic ce_a_n;
        logic ce_b_n;
        logic oe_n;
        logic we_n;
        logic wp_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } fcse_pins_type;

    localparam fcse_pins_type PINS_RESET = '{
        ce_a_n: 1'b1, ce_b_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, wp_n: 1'b0,
        addr: '0, dq_out: '0, dq_oe: 1'b0};
endpackage

/* File: verification/fcse_flash_model.sv */
`timescale 1ns/1ps
module fcse_flash_model #(
    parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEV_CODE = 8'hc3, // Arbitrary value
    parameter int NBLK = 32,
    parameter int ERASE_NS = 100
) (
    input wire fcse_pkg::fcse_pins_type pins,
    input wire logic supply_ok,
    input wire logic [63:0] lock_mask,
    input wire logic [63:0] fail_mask,
    output logic [7:0] dq,
    output logic status_pin
);
    logic [1:0] mode; // 0 array, 1 id, 2 status, 3 extended
    logic [1:0] setup; // 1 block, 2 chip
    logic [7:0] sr;
    logic [7:0] latch;
    logic [63:0] erase_st;
    logic ready;
    logic sel;
    logic rd;
    logic wr;
    logic [20:0] idx;
    int blk;
    // Bus decode; a released bus shows the inverse of the last value
    assign sel = !pins.ce_a_n && !pins.ce_b_n;
    assign rd = sel && !pins.oe_n;
    assign wr = sel && !pins.we_n;
    assign dq = rd ? latch : ~latch;
    assign status_pin = ready;
    initial begin
        mode = 2'h0;
        setup = 2'h0;
        sr = 8'h00;
        latch = 8'h00;
        erase_st = '0;
        ready = 1'b1;
    end
    // Erase engine, one block, or all blocks upward except locked ones while wp_n is low
    task automatic erase_blocks(input bit chip, input int first);
        int last_b;
        last_b = chip ? NBLK - 1 : first;
        ready = 1'b0;
        for (int b = chip ? 0 : first; b <= last_b; b++) begin
            if (!(chip && lock_mask[b] && !pins.wp_n)) begin
                #(ERASE_NS);
                erase_st[b] = fail_mask[b];
                if (fail_mask[b]) sr[5] = 1'b1;
            end
        end
        ready = 1'b1;
    endtask
    // Command writes taken as write enable or chip enable rises
    always @(negedge wr) begin
        blk = int'(pins.addr[21:16]);
        if (setup != 2'h0) begin
            mode = 2'h2;
            if (pins.dq_out != 8'h07) sr[5:4] = 2'b11;
            else if (!supply_ok) sr = sr | 8'h28;
            else if (setup == 2'h1 && lock_mask[blk] && !pins.wp_n) sr = sr | 8'h22;
            else erase_blocks(setup == 2'h2, blk);
            setup = 2'h0;
        end else begin
            case (pins.dq_out)
                8'h01: mode = 2'h1;
                8'h02: mode = 2'h2;
                8'h03: sr = 8'h00;
                8'h04: mode = 2'h3;
                8'h05: setup = 2'h1;
                8'h06: setup = 2'h2;
                default: mode = 2'h0;
            endcase
        end
    end
    // Output latch loads on the last falling enable
    always @(posedge rd) begin
        idx = pins.addr[21:1];
        blk = int'(pins.addr[21:16]);
        case (mode)
            2'h1: latch = idx == 21'h0 ? MFR_CODE : idx == 21'h1 ? DEV_CODE :
                idx[14:0] == 15'h2 ? {6'h00, erase_st[blk], lock_mask[blk]} : 8'h00;
            2'h2: latch = ready ? {1'b1, sr[6:0]} : {1'b0, ~latch[6:0]};
            2'h3: latch = 8'h80;
            default: latch = 8'hff;
        endcase
    end
endmodule

/* File: verification/flash_cmd_status_erase_ctrl_test.sv */
`timescale 1ns/1ps
module flash_cmd_status_erase_ctrl_test;
    typedef struct {
        fcse_pkg::fcse_op_type op;
        logic [21:0] addr;
        logic wp;
        logic [7:0] res;
        logic ef;
    } fcse_case_type;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    fcse_pkg::fcse_req_type req = '0;
    logic req_ready;
    fcse_pkg::fcse_pins_type pins;
    logic [7:0] dq_in;
    logic status_pin;
    logic done;
    logic [7:0] result;
    logic erase_failed;
    logic supply_ok = 1'b1;
    logic [63:0] lock_mask = 64'h0000_0000_0000_0008;
    logic [63:0] fail_mask = 64'h0000_0000_0000_0020;
    int mismatches = 0;
    int cmp_count = 0;
    fcse_case_type rows [12];
    fcse_host dut_u (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .pins(pins), .dq_in(dq_in), .status_pin(status_pin),
        .done(done), .result(result), .erase_failed(erase_failed));
    fcse_flash_model model_u (.pins(pins), .supply_ok(supply_ok), .lock_mask(lock_mask),
        .fail_mask(fail_mask), .dq(dq_in), .status_pin(status_pin));
    // Clock
    always #5 clk_sys = ~clk_sys;
    task automatic bad(input string m);
        mismatches++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic check8(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) bad($sformatf("byte %h expected %h", g, e));
    endtask
    task automatic check1(input logic g, input logic e);
        cmp_count++;
        if (g !== e) bad($sformatf("bit %b expected %b", g, e));
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // One request, then a bounded wait for the done pulse
    task automatic do_op(input fcse_pkg::fcse_op_type op, input logic [21:0] a, input logic wp);
        int n;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{op: op, addr: a, wp_high: wp};
        @(posedge clk_sys);
        req_valid <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 3000) bad("no done");
    endtask
    // Watchdog
    initial begin
        repeat (40000) @(posedge clk_sys);
        bad("timeout");
        results();
    end
    // Main sequence
    initial begin
        rows = '{
            '{fcse_pkg::OP_READ_ID, 22'h0_0000, 1'b0, 8'h5a, 1'b0},
            '{fcse_pkg::OP_READ_ID, 22'h0_0001, 1'b0, 8'hc3, 1'b0},
            '{fcse_pkg::OP_READ_ID, 22'h1_8002, 1'b0, 8'h01, 1'b0},
            '{fcse_pkg::OP_READ_STATUS, 22'h0_0000, 1'b0, 8'h80, 1'b0},
            '{fcse_pkg::OP_READ_XSR, 22'h0_0000, 1'b0, 8'h80, 1'b0},
            '{fcse_pkg::OP_BLOCK_ERASE, 22'h2_0000, 1'b0, 8'h80, 1'b0},
            '{fcse_pkg::OP_BLOCK_ERASE, 22'h3_0000, 1'b0, 8'ha2, 1'b1},
            '{fcse_pkg::OP_READ_STATUS, 22'h0_0000, 1'b0, 8'h80, 1'b0},
            '{fcse_pkg::OP_BLOCK_ERASE, 22'h3_0000, 1'b1, 8'h80, 1'b0},
            '{fcse_pkg::OP_CHIP_ERASE, 22'h0_0000, 1'b0, 8'ha0, 1'b1},
            '{fcse_pkg::OP_READ_ID, 22'h2_8002, 1'b0, 8'h02, 1'b0},
            '{fcse_pkg::OP_READ_ID, 22'h1_8002, 1'b0, 8'h01, 1'b0}};
        repeat (3) @(posedge clk_sys);
        check1(req_ready, 1'b1);
        check1(pins.we_n, 1'b1);
        check1(done, 1'b0);
        check8(result, 8'h00);
        repeat (17) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            do_op(rows[i].op, rows[i].addr, rows[i].wp);
            check8(result, rows[i].res);
            check1(erase_failed, rows[i].ef);
        end
        // Supply at lockout level
        supply_ok <= 1'b0;
        do_op(fcse_pkg::OP_READ_ID, 22'h0_0000, 1'b0);
        check8(result, 8'h5a);
        do_op(fcse_pkg::OP_BLOCK_ERASE, 22'h2_0000, 1'b0);
        check8(result, 8'ha8);
        check1(erase_failed, 1'b1);
        supply_ok <= 1'b1;
        do_op(fcse_pkg::OP_CLEAR_STATUS, 22'h0_0000, 1'b0);
        do_op(fcse_pkg::OP_READ_STATUS, 22'h0_0000, 1'b0);
        check8(result, 8'h80);
        // Reset in the middle of a read
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{op: fcse_pkg::OP_READ_STATUS, addr: 22'h0_0000, wp_high: 1'b0};
        @(posedge clk_sys);
        req_valid <= 1'b0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check1(pins.oe_n, 1'b1);
        check1(req_ready, 1'b1);
        rst <= 1'b0;
        do_op(fcse_pkg::OP_READ_ID, 22'h0_0001, 1'b0);
        check8(result, 8'hc3);
        results();
    end
endmodule
